// >>> sem_flags_pkg.sv
/*
 * constants and types shared by the dual-port semaphore flag block.
 * assumes one synchronous clock for both ports.
 */
package sem_flags_pkg;
    localparam int FLAG_COUNT   = 8;
    localparam int FLAG_ADDR_W  = 3;
    localparam int DATA_W       = 8;
    localparam int DATA_BIT_SEL = 0;
    // request latch value meaning "no request" / "free"
    localparam logic REQ_IDLE   = 1'b1;
    localparam logic REQ_ACTIVE = 1'b0;
    // owner encoding of a flag
    typedef enum logic [1:0] {
        OWN_FREE  = 2'b00,
        OWN_LEFT  = 2'b01,
        OWN_RIGHT = 2'b11
    } owner_t;
endpackage

// >>> sem_flags.sv
/*
 * eight semaphore flags shared by a left and a right port, each with its
 * own select, output enable, read/write, address and data pins.
 * assumes all port inputs are asynchronous pins; the used bits pass two flops.
 */
// Notes on behaviour
// - eight single-bit flags separate from RAM.
// - low semaphore select plus sram-style controls.
// - only three low address bits pick flag.
// - write value taken from data bit zero.
// - zero on free flag grants writer ownership.
// - owner writing one frees flag if unrequested.
// - non-owner zero stays pending in request latch.
// - pending request takes flag on owner release.
// - read spreads flag value over all bits.
// - read value frozen while select and enable.
// - writing one cancels a pending request.
// - non-owner zero leaves visible values unchanged.
// - flags gate nothing; ports never stall.
// - earlier request wins; left wins a same-cycle tie.
`timescale 1ns/1ps
module sem_flags
    import sem_flags_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              CLK_IN,
    input  wire logic              RST_IN,
    input  wire logic              L_SEMAPHORE_SPACE_SELECT_N_IN,
    input  wire logic              L_OE_N_IN,
    input  wire logic              L_RW_IN,
    input  wire logic [ADDR_W-1:0] L_ADDR_IN,
    input  wire logic [DATA_W-1:0] L_DATA_IN,
    output logic      [DATA_W-1:0] L_DATA_OUT,
    output logic                   L_DATA_OE_OUT,
    input  wire logic              R_SEMAPHORE_SPACE_SELECT_N_IN,
    input  wire logic              R_OE_N_IN,
    input  wire logic              R_RW_IN,
    input  wire logic [ADDR_W-1:0] R_ADDR_IN,
    input  wire logic [DATA_W-1:0] R_DATA_IN,
    output logic      [DATA_W-1:0] R_DATA_OUT,
    output logic                   R_DATA_OE_OUT
);

    // ******************************************************************
    // elaboration checks
    // ******************************************************************
    if (ADDR_W < FLAG_ADDR_W) begin : g_addr_chk
        $error("address narrower than flag select");
    end
    if ((1 << FLAG_ADDR_W) != FLAG_COUNT) begin : g_count_chk
        $error("flag count does not match flag select width");
    end
    if (DATA_BIT_SEL >= DATA_W) begin : g_bit_chk
        $error("write data bit outside data bus");
    end

    // synchroniser word: {sel_n, oe_n, rw, addr, write data bit}
    localparam int D0_POS   = 0;
    localparam int ADDR_LSB = D0_POS + 1;
    localparam int ADDR_MSB = ADDR_LSB + FLAG_ADDR_W - 1;
    localparam int RW_POS   = ADDR_MSB + 1;
    localparam int OE_POS   = RW_POS + 1;
    localparam int SEL_POS  = OE_POS + 1;
    localparam int PIN_W    = SEL_POS + 1;

    // ******************************************************************
    // state
    // ******************************************************************
    typedef struct packed {
        logic [PIN_W-1:0]      l_s1;
        logic [PIN_W-1:0]      l_s2;
        logic [PIN_W-1:0]      r_s1;
        logic [PIN_W-1:0]      r_s2;
        logic [FLAG_COUNT-1:0] l_req;
        logic [FLAG_COUNT-1:0] r_req;
        owner_t [FLAG_COUNT-1:0] owner;
        logic                  l_wr_d;
        logic                  r_wr_d;
        logic                  l_rd_act;
        logic                  r_rd_act;
        logic [DATA_W-1:0]     l_dout;
        logic [DATA_W-1:0]     r_dout;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    // synchroniser field layout: {sel_n, oe_n, rw, addr[2:0], d0}
    logic                   l_sel;
    logic                   l_oe;
    logic                   l_rw;
    logic [FLAG_ADDR_W-1:0] l_idx;
    logic                   l_d0;
    logic                   r_sel;
    logic                   r_oe;
    logic                   r_rw;
    logic [FLAG_ADDR_W-1:0] r_idx;
    logic                   r_d0;
    logic                   l_wr_lvl;
    logic                   r_wr_lvl;
    logic                   l_wr_evt;
    logic                   r_wr_evt;
    logic [FLAG_COUNT-1:0]  l_view;
    logic [FLAG_COUNT-1:0]  r_view;

    always_comb begin
        l_sel = ~state_r.l_s2[SEL_POS];
        l_oe  = ~state_r.l_s2[OE_POS];
        l_rw  = state_r.l_s2[RW_POS];
        l_idx = state_r.l_s2[ADDR_MSB:ADDR_LSB];
        l_d0  = state_r.l_s2[D0_POS];
        r_sel = ~state_r.r_s2[SEL_POS];
        r_oe  = ~state_r.r_s2[OE_POS];
        r_rw  = state_r.r_s2[RW_POS];
        r_idx = state_r.r_s2[ADDR_MSB:ADDR_LSB];
        r_d0  = state_r.r_s2[D0_POS];
        l_wr_lvl = l_sel & ~l_rw;
        r_wr_lvl = r_sel & ~r_rw;
        // one update per write strobe, at its leading edge
        l_wr_evt = l_wr_lvl & ~state_r.l_wr_d;
        r_wr_evt = r_wr_lvl & ~state_r.r_wr_d;
        for (int i = 0; i < FLAG_COUNT; i++) begin
            l_view[i] = (state_r.owner[i] != OWN_LEFT);
            r_view[i] = (state_r.owner[i] != OWN_RIGHT);
        end
    end

    // ******************************************************************
    // next state
    // ******************************************************************
    always_comb begin
        state_nxt = state_r;
        state_nxt.l_s1 = {L_SEMAPHORE_SPACE_SELECT_N_IN, L_OE_N_IN, L_RW_IN,
                          L_ADDR_IN[FLAG_ADDR_W-1:0], L_DATA_IN[DATA_BIT_SEL]};
        state_nxt.r_s1 = {R_SEMAPHORE_SPACE_SELECT_N_IN, R_OE_N_IN, R_RW_IN,
                          R_ADDR_IN[FLAG_ADDR_W-1:0], R_DATA_IN[DATA_BIT_SEL]};
        state_nxt.l_s2 = state_r.l_s1;
        state_nxt.r_s2 = state_r.r_s1;
        state_nxt.l_wr_d = l_wr_lvl;
        state_nxt.r_wr_d = r_wr_lvl;

        // request latches take data bit zero on each write
        if (l_wr_evt)
            state_nxt.l_req[l_idx] = l_d0;
        if (r_wr_evt)
            state_nxt.r_req[r_idx] = r_d0;

        // arbitration per flag on the updated request latches
        for (int i = 0; i < FLAG_COUNT; i++) begin
            case (state_r.owner[i])
                OWN_FREE: begin
                    if (state_nxt.l_req[i] == REQ_ACTIVE)
                        state_nxt.owner[i] = OWN_LEFT;
                    else if (state_nxt.r_req[i] == REQ_ACTIVE)
                        state_nxt.owner[i] = OWN_RIGHT;
                end
                OWN_LEFT: begin
                    if (state_nxt.l_req[i] == REQ_IDLE) begin
                        if (state_nxt.r_req[i] == REQ_ACTIVE)
                            state_nxt.owner[i] = OWN_RIGHT;
                        else
                            state_nxt.owner[i] = OWN_FREE;
                    end
                end
                OWN_RIGHT: begin
                    if (state_nxt.r_req[i] == REQ_IDLE) begin
                        if (state_nxt.l_req[i] == REQ_ACTIVE)
                            state_nxt.owner[i] = OWN_LEFT;
                        else
                            state_nxt.owner[i] = OWN_FREE;
                    end
                end
                default: state_nxt.owner[i] = OWN_FREE;
            endcase
        end

        // read capture, frozen until select or enable drops
        state_nxt.l_rd_act = l_sel & l_oe & l_rw;
        state_nxt.r_rd_act = r_sel & r_oe & r_rw;
        if (state_nxt.l_rd_act & ~state_r.l_rd_act)
            state_nxt.l_dout = {DATA_W{l_view[l_idx]}};
        if (state_nxt.r_rd_act & ~state_r.r_rd_act)
            state_nxt.r_dout = {DATA_W{r_view[r_idx]}};
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_r.l_s1     <= '1;
            state_r.l_s2     <= '1;
            state_r.r_s1     <= '1;
            state_r.r_s2     <= '1;
            state_r.l_req    <= '1;
            state_r.r_req    <= '1;
            for (int i = 0; i < FLAG_COUNT; i++) begin
                state_r.owner[i] <= OWN_FREE;
            end
            state_r.l_wr_d   <= 1'b0;
            state_r.r_wr_d   <= 1'b0;
            state_r.l_rd_act <= 1'b0;
            state_r.r_rd_act <= 1'b0;
            state_r.l_dout   <= '1;
            state_r.r_dout   <= '1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ports never wait on each other; no busy output exists
    assign L_DATA_OUT    = state_r.l_dout;
    assign R_DATA_OUT    = state_r.r_dout;
    assign L_DATA_OE_OUT = state_r.l_rd_act;
    assign R_DATA_OE_OUT = state_r.r_rd_act;

    // ******************************************************************
    // checks
    // ******************************************************************
    // a zero from one port on a free flag; left wins a same-cycle tie
    sequence l_take_free;
        l_wr_evt && !l_d0 && state_r.owner[l_idx] == OWN_FREE;
    endsequence
    sequence r_take_free;
        r_wr_evt && !r_d0 && state_r.owner[r_idx] == OWN_FREE
        && !(l_wr_evt && !l_d0 && l_idx == r_idx);
    endsequence
    sequence both_take_free;
        l_wr_evt && r_wr_evt && !l_d0 && !r_d0 && l_idx == r_idx
        && state_r.owner[l_idx] == OWN_FREE;
    endsequence
    // the owner writes a one, with or without the other side waiting
    sequence l_release_wait;
        l_wr_evt && l_d0 && state_r.owner[l_idx] == OWN_LEFT
        && state_r.r_req[l_idx] == REQ_ACTIVE
        && !(r_wr_evt && r_idx == l_idx);
    endsequence
    sequence l_release_free;
        l_wr_evt && l_d0 && state_r.owner[l_idx] == OWN_LEFT
        && state_r.r_req[l_idx] == REQ_IDLE
        && !(r_wr_evt && r_idx == l_idx);
    endsequence
    sequence r_release_wait;
        r_wr_evt && r_d0 && state_r.owner[r_idx] == OWN_RIGHT
        && state_r.l_req[r_idx] == REQ_ACTIVE
        && !(l_wr_evt && l_idx == r_idx);
    endsequence
    sequence r_release_free;
        r_wr_evt && r_d0 && state_r.owner[r_idx] == OWN_RIGHT
        && state_r.l_req[r_idx] == REQ_IDLE
        && !(l_wr_evt && l_idx == r_idx);
    endsequence

    AST_EXCLUSIVE: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (~l_view & ~r_view) == '0)
        else $error("both ports own one flag");
    AST_LEFT_GRANT: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        l_take_free |=> state_r.owner[$past(l_idx)] == OWN_LEFT)
        else $error("left zero on free flag not granted");
    AST_RIGHT_GRANT: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        r_take_free |=> state_r.owner[$past(r_idx)] == OWN_RIGHT)
        else $error("right zero on free flag not granted");
    AST_LEFT_PRIO: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        both_take_free |=> state_r.owner[$past(l_idx)] == OWN_LEFT)
        else $error("left lacks priority");
    AST_PENDING: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (r_wr_evt && !r_d0) |=> state_r.r_req[$past(r_idx)] == REQ_ACTIVE)
        else $error("right zero not held as request");
    AST_PENDING_L: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (l_wr_evt && !l_d0) |=> state_r.l_req[$past(l_idx)] == REQ_ACTIVE)
        else $error("left zero not held as request");
    AST_HOLD: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (r_wr_evt && !r_d0 && state_r.owner[r_idx] == OWN_LEFT
         && !l_wr_evt) |=> $stable(state_r.owner))
        else $error("non-owner zero changed flag");
    AST_HOLD_L: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (l_wr_evt && !l_d0 && state_r.owner[l_idx] == OWN_RIGHT
         && !r_wr_evt) |=> $stable(state_r.owner))
        else $error("left non-owner zero changed flag");
    AST_HANDOVER: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        l_release_wait |=> state_r.owner[$past(l_idx)] == OWN_RIGHT)
        else $error("pending request not granted");
    AST_HANDOVER_R: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        r_release_wait |=> state_r.owner[$past(r_idx)] == OWN_LEFT)
        else $error("left pending request not granted");
    AST_FREE: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        l_release_free |=> state_r.owner[$past(l_idx)] == OWN_FREE)
        else $error("release did not free flag");
    AST_FREE_R: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        r_release_free |=> state_r.owner[$past(r_idx)] == OWN_FREE)
        else $error("right release did not free flag");
    AST_CANCEL: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (r_wr_evt && r_d0) |=> state_r.r_req[$past(r_idx)] == REQ_IDLE)
        else $error("request not cleared");
    AST_CANCEL_L: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (l_wr_evt && l_d0) |=> state_r.l_req[$past(l_idx)] == REQ_IDLE)
        else $error("left request not cleared");
    AST_SPREAD: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (L_DATA_OUT == '0 || L_DATA_OUT == '1)
        && (R_DATA_OUT == '0 || R_DATA_OUT == '1))
        else $error("read data not spread");
    AST_FROZEN: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_r.l_rd_act && $past(state_r.l_rd_act))
        |-> $stable(L_DATA_OUT))
        else $error("read data changed during read");
    AST_FROZEN_R: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_r.r_rd_act && $past(state_r.r_rd_act))
        |-> $stable(R_DATA_OUT))
        else $error("right read data changed during read");

endmodule // sem_flags

// >>> sem_cpu_model.sv
/*
 * processor model for one semaphore port: write and read cycles.
 * assumes a 50 MHz clock and the design's two-flop input sync.
 */
`timescale 1ns/1ps
module sem_cpu_model
    import sem_flags_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              CLK_IN,
    input  wire logic [DATA_W-1:0] DATA_IN,
    input  wire logic              DATA_OE_IN,
    output logic                   SEL_N_OUT,
    output logic                   OE_N_OUT,
    output logic                   RW_OUT,
    output logic      [ADDR_W-1:0] ADDR_OUT,
    output logic      [DATA_W-1:0] DATA_OUT
);
    initial begin
        SEL_N_OUT = 1'b1;
        OE_N_OUT = 1'b1;
        RW_OUT = 1'b1;
        ADDR_OUT = '0;
        DATA_OUT = 8'h55;
    end
    // write strobe: select low, rw low, noise on unused data bits
    task automatic wr(input logic [ADDR_W-1:0] a, input logic b);
        @(posedge CLK_IN) #1;
        ADDR_OUT = a;
        DATA_OUT = {{7{~b}}, b};
        RW_OUT = 1'b0;
        SEL_N_OUT = 1'b0;
        repeat (4) @(posedge CLK_IN);
        #1 SEL_N_OUT = 1'b1;
        RW_OUT = 1'b1;
        DATA_OUT = ~DATA_OUT;
        ADDR_OUT = ~ADDR_OUT;
        repeat (3) @(posedge CLK_IN);
    endtask
    // read cycle; select and enable dropped afterwards for a new capture
    task automatic rd(input logic [ADDR_W-1:0] a, input int hold,
                      output logic [DATA_W-1:0] d, output logic oe);
        @(posedge CLK_IN) #1;
        ADDR_OUT = a;
        SEL_N_OUT = 1'b0;
        OE_N_OUT = 1'b0;
        repeat (4 + hold) @(posedge CLK_IN);
        #1 d = DATA_IN;
        oe = DATA_OE_IN;
        SEL_N_OUT = 1'b1;
        OE_N_OUT = 1'b1;
        ADDR_OUT = ~ADDR_OUT;
        repeat (3) @(posedge CLK_IN);
    endtask
endmodule // sem_cpu_model

// >>> sem_flags_bench.sv
/*
 * self-checking bench for the semaphore flags, two processor models.
 * assumes the design answers reads within four clock edges.
 */
`timescale 1ns/1ps
module sem_flags_bench;
    import sem_flags_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              l_sel_n, l_oe_n, l_rw, r_sel_n, r_oe_n, r_rw;
    logic              l_oe, r_oe;
    logic [11:0]       l_addr, r_addr;
    logic [DATA_W-1:0] l_wd, r_wd, l_rd, r_rd;
    int                error_cnt = 0;
    int                checks_done = 0;
    always #10 clk = ~clk;
    sem_flags #(.ADDR_W(12)) sem_flags_inst (.CLK_IN(clk), .RST_IN(rst),
        .L_SEMAPHORE_SPACE_SELECT_N_IN(l_sel_n), .L_OE_N_IN(l_oe_n),
        .L_RW_IN(l_rw), .L_ADDR_IN(l_addr), .L_DATA_IN(l_wd),
        .L_DATA_OUT(l_rd), .L_DATA_OE_OUT(l_oe),
        .R_SEMAPHORE_SPACE_SELECT_N_IN(r_sel_n), .R_OE_N_IN(r_oe_n),
        .R_RW_IN(r_rw), .R_ADDR_IN(r_addr), .R_DATA_IN(r_wd),
        .R_DATA_OUT(r_rd), .R_DATA_OE_OUT(r_oe));
    sem_cpu_model left_cpu (.CLK_IN(clk), .DATA_IN(l_rd), .DATA_OE_IN(l_oe),
        .SEL_N_OUT(l_sel_n), .OE_N_OUT(l_oe_n), .RW_OUT(l_rw),
        .ADDR_OUT(l_addr), .DATA_OUT(l_wd));
    sem_cpu_model right_cpu (.CLK_IN(clk), .DATA_IN(r_rd), .DATA_OE_IN(r_oe),
        .SEL_N_OUT(r_sel_n), .OE_N_OUT(r_oe_n), .RW_OUT(r_rw),
        .ADDR_OUT(r_addr), .DATA_OUT(r_wd));
    // ****
    // helpers
    // ****
    function automatic logic [11:0] adr(input int f);
        return {9'h1a5, 3'(f)};
    endfunction
    task automatic chk(input logic [7:0] got, exp, input logic oe);
        checks_done++;
        if (got !== exp || oe !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t read %h oe %b expected %h", $time, got, oe, exp);
        end
    endtask
    task automatic rd_both(input int f, input logic [7:0] el, er);
        logic [7:0] dl, dr;
        logic       ol, orr;
        fork
            left_cpu.rd(adr(f), 0, dl, ol);
            right_cpu.rd(adr(f), 0, dr, orr);
        join
        chk(dl, el, ol);
        chk(dr, er, orr);
        #1;
        checks_done++;
        if (l_oe !== 1'b0 || r_oe !== 1'b0) begin
            error_cnt++;
            $display("BAD %0t drive enable stays on after read", $time);
        end
    endtask
    task automatic step(input bit rs, input int f, input logic b,
                        input logic [7:0] el, er);
        if (rs) right_cpu.wr(adr(f), b);
        else left_cpu.wr(adr(f), b);
        rd_both(f, el, er);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_init();
        for (int f = 0; f < 8; f++) begin
            rd_both(f, 8'hff, 8'hff);
            fork
                left_cpu.wr(adr(f), 1'b1);
                right_cpu.wr(adr(f), 1'b1);
            join
        end
    endtask
    task automatic t_table();
        step(0, 3, 1'b0, 8'h00, 8'hff);
        step(1, 3, 1'b0, 8'h00, 8'hff);
        step(0, 3, 1'b1, 8'hff, 8'h00);
        step(0, 3, 1'b0, 8'hff, 8'h00);
        step(1, 3, 1'b1, 8'h00, 8'hff);
        step(0, 3, 1'b1, 8'hff, 8'hff);
        step(1, 3, 1'b0, 8'hff, 8'h00);
        step(1, 3, 1'b1, 8'hff, 8'hff);
    endtask
    task automatic t_cancel();
        step(0, 5, 1'b0, 8'h00, 8'hff);
        step(1, 5, 1'b0, 8'h00, 8'hff);
        step(1, 5, 1'b1, 8'h00, 8'hff);
        step(0, 5, 1'b1, 8'hff, 8'hff);
    endtask
    task automatic t_same();
        fork
            left_cpu.wr(adr(6), 1'b0);
            right_cpu.wr(adr(6), 1'b0);
        join
        rd_both(6, 8'h00, 8'hff);
        step(0, 6, 1'b1, 8'hff, 8'h00);
        step(1, 6, 1'b1, 8'hff, 8'hff);
    endtask
    task automatic t_freeze();
        logic [7:0] d;
        logic       oe;
        step(0, 2, 1'b0, 8'h00, 8'hff);
        step(1, 2, 1'b0, 8'h00, 8'hff);
        fork
            right_cpu.rd(adr(2), 12, d, oe);
            begin
                repeat (2) @(posedge clk);
                left_cpu.wr(adr(2), 1'b1);
            end
        join
        chk(d, 8'hff, oe);
        rd_both(2, 8'hff, 8'h00);
        step(1, 2, 1'b1, 8'hff, 8'hff);
    endtask
    task automatic summarize();
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        t_init();
        t_table();
        t_cancel();
        t_same();
        t_freeze();
        summarize();
    end
endmodule // sem_flags_bench
